/* rfb_rx_frame_buffer.sv */
// Receive frame pre-processing, on-chip holding and host readout
// Functional notes
// RL1 - Config bit 7 enables streaming receive
// RL2 - Config bit 9 sends every frame by DMA
// RL3 - Config bit A enables DMA auto switch
// RL4 - Bounded hold limits DMA bus to 28 us
// RL5 - Bus control bit F selects 64K/16K buffer
// RL6 - Frames failing address filter are discarded
// RL7 - Destination pass sets early destination flag
// RL8 - 128 bytes set flag, clear destination flag
// RL9 - 128 flag cleared by read or end
// RL10 - Other event bits clear only on read
// RL11 - Acceptance decides buffering, reported in event
// RL12 - Normal interrupts after whole frame buffered
// RL13 - Accepted frames held or sent by DMA
// RL14 - Commit after full frame and event read
// RL15 - Commit partial frame after buffer event read
// RL16 - Committed space never overwritten by later frames
// RL17 - Sequential full read releases the frame
// RL18 - Skip bit releases partly read frame
// RL19 - Early interrupts suppressed while frame committed
// RL20 - Data at 0404h, I/O gives status, length first
// RL21 - One frame visible: status, length offsets
// RL22 - Buffer shortage flags missed frame, interrupt
// RL23 - Skip drops rest, next frame visible

`include "rfb_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module rfb_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge ref_clk) begin
    if (ce && push) begin
      mem[wp_r] <= in_data;
    end
  end

  // Ready is registered so the line sees back-pressure from a flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b1;
    end else if (ce) begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != (AW+1)'(DEPTH));
    end
  end
endmodule // rfb_fifo

////////////////////////////////////////////////////////////////////////////////
module rfb_rx_frame_buffer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic rx_valid,
  input wire rfb_pkg::rfb_word_t rx_word,
  output logic rx_ready,
  input wire logic pp_rd,
  input wire logic pp_wr,
  input wire logic [11:0] pp_addr,
  input wire logic [15:0] pp_wdata,
  input wire logic io_rd,
  output logic [15:0] rdata_r,
  output logic rvalid_r,
  output logic irq_r,
  output logic dma_req_r,
  input wire logic dma_ack,
  output logic [15:0] dma_data_r,
  output logic stream_mode_r,
  output logic dma_buf_64k_r
);
  import rfb_pkg::*;

  logic [7:0] ram [4096];
  rfb_desc_t desc [4];
  rfb_wr_state_t state_r;
  rfb_word_t w;
  logic fv;
  logic f_rdy;
  logic [15:0] rx_config;
  logic [15:0] rx_accept_control;
  logic [15:0] buffer_config_reg;
  logic [15:0] bus_control;
  logic [15:0] rx_event_reg;
  logic [15:0] buffer_event_reg;
  logic [11:0] wptr_r;
  logic [11:0] frame_start_r;
  logic [10:0] byte_cnt_r;
  logic cur_commit_r;
  logic [1:0] head_r;
  logic [1:0] tail_r;
  logic [2:0] dcnt_r;
  logic [10:0] rd_off_r;
  logic [1:0] io_phase_r;
  logic head_commit_r;
  logic [11:0] hold_cnt_r;
  rfb_desc_t hd;

  function automatic logic [15:0] rd16(input logic [11:0] a);
    rd16 = {ram[a + 12'h001], ram[a]};
  endfunction

  rfb_fifo #(.WIDTH($bits(rfb_word_t)), .DEPTH(16)) u_fifo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data(rx_word),
    .out_valid(fv),
    .out_ready(f_rdy),
    .out_data(w)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Writer: filtering and storing incoming bytes
  logic keep;
  logic too_long;
  logic space_ok;
  logic da_fail;
  logic drop_now;
  logic wr_en;
  logic fire;
  logic push;
  logic pop;
  logic [11:0] used;
  logic to_dma;

  assign hd = desc[head_r];
  assign used = wptr_r - ((dcnt_r == 3'd0) ? frame_start_r : hd.start);
  assign keep = (state_r == RFB_RECV);
  assign too_long = (byte_cnt_r >= `RFB_MAX_LEN);
  // Committed and waiting frames are never overrun by a new one
  assign space_ok = (used != `RFB_RAM_FULL);
  assign da_fail = (byte_cnt_r == `RFB_DEST_LAST) && !w.da_ok;
  assign drop_now = keep && ((!space_ok && !too_long) || da_fail);
  assign wr_en = keep && !drop_now && !too_long;
  // Stall the line while no descriptor slot is free for a finishing frame
  assign f_rdy = !(keep && w.last && dcnt_r == `RFB_DQ_DEPTH);
  assign fire = fv && f_rdy;
  assign push = fire && keep && !drop_now && w.last && w.accept && w.da_ok;
  // RL3 auto switch: DMA once on-chip space runs low
  assign to_dma = rx_config[`RFB_CFG_DMA_ALWAYS] ||
                  (rx_config[`RFB_CFG_AUTO_DMA] && used >= `RFB_AUTO_LOW);

  always_ff @(posedge ref_clk) begin
    if (ce && fire && wr_en) begin
      ram[wptr_r] <= w.data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RFB_RECV;
      wptr_r <= '0;
      frame_start_r <= '0;
      byte_cnt_r <= '0;
      tail_r <= '0;
    end else if (ce && fire) begin
      byte_cnt_r <= w.last ? 11'd0 : byte_cnt_r + 11'(byte_cnt_r != 11'h7FF);
      if (w.last) begin
        state_r <= RFB_RECV;
        // RL11 accept or discard
        if (push) begin
          wptr_r <= wptr_r + 12'(wr_en);
          frame_start_r <= wptr_r + 12'(wr_en);
          tail_r <= tail_r + 2'd1;
        end else begin
          wptr_r <= frame_start_r;
        end
      end else if (drop_now) begin
        // RL6 filter failure discards
        state_r <= RFB_DROP;
        wptr_r <= frame_start_r;
      end else if (wr_en) begin
        wptr_r <= wptr_r + 12'd1;
      end
    end
  end

  // RL13 held or DMAed
  always_ff @(posedge ref_clk) begin
    if (ce && push) begin
      desc[tail_r] <= '{start: frame_start_r,
                        len: byte_cnt_r + 11'(wr_en),
                        status: {1'b0, w.kind[3:1], 3'b000, w.kind[0], 8'h00},
                        dma: to_dma,
                        commit: cur_commit_r};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register page access and readout
  logic rd_cfg;
  logic isq_rd;
  logic ev_rd;
  logic bev_rd;
  logic skip;
  logic host_adv;
  logic dma_take;
  logic adv;
  logic at_end;
  logic committed;

  assign isq_rd = pp_rd && pp_addr == `RFB_OFS_ISQ;
  assign ev_rd = (pp_rd && pp_addr == `RFB_OFS_RX_EVENT) || (isq_rd && rx_event_reg != '0);
  assign bev_rd = (pp_rd && pp_addr == `RFB_OFS_BUF_EVENT) ||
                  (isq_rd && rx_event_reg == '0 && buffer_event_reg != '0);
  assign rd_cfg = pp_wr && pp_addr == `RFB_OFS_RX_CONFIG;
  // RL18 skip command
  assign skip = rd_cfg && pp_wdata[`RFB_CFG_SKIP];
  // RL20 memory and I/O data paths
  assign host_adv = !hd.dma && ((pp_rd && pp_addr == `RFB_OFS_RX_DATA) ||
                                (io_rd && io_phase_r == 2'd2));
  assign dma_take = hd.dma && dma_req_r && dma_ack;
  assign adv = (dcnt_r != 3'd0) && (host_adv || dma_take);
  assign at_end = ({1'b0, rd_off_r} + 12'd2) >= {1'b0, hd.len};
  // RL17 full sequential read releases
  assign pop = (dcnt_r != 3'd0) && ((adv && at_end) || skip);
  assign committed = (dcnt_r != 3'd0) && (head_commit_r || hd.commit);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_config <= `RFB_RST_CFG;
      rx_accept_control <= `RFB_RST_CFG;
      buffer_config_reg <= `RFB_RST_CFG;
      bus_control <= `RFB_RST_CFG;
    end else if (ce && pp_wr) begin
      case (pp_addr)
        // Skip is a command and never reads back
        `RFB_OFS_RX_CONFIG: rx_config <= pp_wdata & ~(16'h0001 << `RFB_CFG_SKIP);
        `RFB_OFS_RX_ACCEPT: rx_accept_control <= pp_wdata;
        `RFB_OFS_BUF_CONFIG: buffer_config_reg <= pp_wdata;
        `RFB_OFS_BUS_CONTROL: bus_control <= pp_wdata;
        default: ;
      endcase
    end
  end

  // RL23 discard rest, next frame visible
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      head_r <= '0;
      dcnt_r <= '0;
      rd_off_r <= '0;
      io_phase_r <= '0;
    end else if (ce) begin
      dcnt_r <= dcnt_r + 3'(push) - 3'(pop);
      if (pop) begin
        head_r <= head_r + 2'd1;
        rd_off_r <= '0;
        io_phase_r <= '0;
      end else begin
        if (adv) begin
          rd_off_r <= rd_off_r + 11'd2;
        end
        if (io_rd && dcnt_r != 3'd0 && io_phase_r != 2'd2) begin
          io_phase_r <= io_phase_r + 2'd1;
        end
      end
    end
  end

  // RL14 commit on event read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      head_commit_r <= 1'b0;
      cur_commit_r <= 1'b0;
    end else if (ce) begin
      if (pop) begin
        head_commit_r <= 1'b0;
      end else if (ev_rd && dcnt_r != 3'd0) begin
        head_commit_r <= 1'b1;
      end
      // RL15 partial frame commit
      if (fire && w.last) begin
        cur_commit_r <= 1'b0;
      end else if (bev_rd && (buffer_event_reg[`RFB_BUF_DEST] ||
                              buffer_event_reg[`RFB_BUF_128])) begin
        cur_commit_r <= 1'b1;
      end
    end
  end

  // RL21 status and length of visible frame
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else if (ce) begin
      rvalid_r <= pp_rd || io_rd;
      if (io_rd) begin
        case (io_phase_r)
          2'd0: rdata_r <= (dcnt_r != 3'd0) ? hd.status : 16'h0000;
          2'd1: rdata_r <= {5'd0, hd.len};
          default: rdata_r <= adv ? rd16(hd.start + {1'b0, rd_off_r}) : 16'h0000;
        endcase
      end else if (pp_rd) begin
        case (pp_addr)
          `RFB_OFS_RX_CONFIG: rdata_r <= rx_config;
          `RFB_OFS_RX_ACCEPT: rdata_r <= rx_accept_control;
          `RFB_OFS_BUF_CONFIG: rdata_r <= buffer_config_reg;
          `RFB_OFS_BUS_CONTROL: rdata_r <= bus_control;
          `RFB_OFS_RX_EVENT: rdata_r <= rx_event_reg | `RFB_REGNUM_RX_EVENT;
          `RFB_OFS_BUF_EVENT: rdata_r <= buffer_event_reg | `RFB_REGNUM_BUF_EVENT;
          `RFB_OFS_ISQ: begin
            if (rx_event_reg != '0) begin
              rdata_r <= rx_event_reg | `RFB_REGNUM_RX_EVENT;
            end else if (buffer_event_reg != '0) begin
              rdata_r <= buffer_event_reg | `RFB_REGNUM_BUF_EVENT;
            end else begin
              rdata_r <= 16'h0000;
            end
          end
          `RFB_OFS_RX_STATUS: rdata_r <= (dcnt_r != 3'd0) ? hd.status : 16'h0000;
          `RFB_OFS_RX_LENGTH: rdata_r <= {5'd0, hd.len};
          `RFB_OFS_RX_DATA: rdata_r <= adv ? rd16(hd.start + {1'b0, rd_off_r}) : 16'h0000;
          default: rdata_r <= 16'h0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event flags; a hardware set always wins over a same-cycle read clear
  logic set_dest;
  logic set_128;
  logic set_miss;
  logic eof;

  // RL7 destination passed
  assign set_dest = fire && wr_en && byte_cnt_r == `RFB_DEST_LAST && w.da_ok;
  // RL8 first 128 bytes
  assign set_128 = fire && wr_en && byte_cnt_r == `RFB_EARLY_LAST;
  // RL22 buffer shortage miss
  assign set_miss = fire && keep && !space_ok && !too_long;
  assign eof = fire && w.last;

  // RL10 read-to-clear events
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_event_reg <= '0;
    end else if (ce) begin
      rx_event_reg <= (ev_rd ? 16'h0000 : rx_event_reg) |
                      (push ? {1'b0, w.kind[3:1], 3'b000, w.kind[0], 8'h00} : 16'h0000);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buffer_event_reg <= '0;
    end else if (ce) begin
      if (bev_rd) begin
        buffer_event_reg[`RFB_BUF_MISS] <= set_miss;
      end else if (set_miss) begin
        buffer_event_reg[`RFB_BUF_MISS] <= 1'b1;
      end
      if (set_dest) begin
        buffer_event_reg[`RFB_BUF_DEST] <= 1'b1;
      end else if (bev_rd || set_128) begin
        buffer_event_reg[`RFB_BUF_DEST] <= 1'b0;
      end
      // RL9 cleared by read or end of frame
      if (set_128) begin
        buffer_event_reg[`RFB_BUF_128] <= 1'b1;
      end else if (bev_rd || eof) begin
        buffer_event_reg[`RFB_BUF_128] <= 1'b0;
      end
    end
  end

  // RL12 normal interrupts after buffering
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else if (ce) begin
      irq_r <= |(rx_event_reg & rx_config & `RFB_CFG_IRQ_MASK) ||
               (buffer_event_reg[`RFB_BUF_MISS] && buffer_config_reg[`RFB_BUF_MISS]) ||
               // RL19 early interrupts held off
               (!committed &&
                ((buffer_event_reg[`RFB_BUF_DEST] && buffer_config_reg[`RFB_BUF_DEST]) ||
                 (buffer_event_reg[`RFB_BUF_128] && buffer_config_reg[`RFB_BUF_128])));
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // DMA slave channel and mode outputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_req_r <= 1'b0;
      dma_data_r <= '0;
      hold_cnt_r <= '0;
    end else if (ce) begin
      // RL4 bounded bus hold
      if (dma_req_r && bus_control[`RFB_BUS_BOUNDED_HOLD] &&
          hold_cnt_r >= 12'(`RFB_DMA_HOLD_CYC - 1)) begin
        dma_req_r <= 1'b0;
        hold_cnt_r <= '0;
      end else begin
        // RL2 DMA frame delivery
        dma_req_r <= (dcnt_r != 3'd0) && hd.dma && !pop;
        hold_cnt_r <= dma_req_r ? hold_cnt_r + 12'd1 : 12'd0;
      end
      if (dma_take) begin
        dma_data_r <= rd16(hd.start + {1'b0, rd_off_r});
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stream_mode_r <= 1'b0;
      dma_buf_64k_r <= 1'b0;
    end else if (ce) begin
      // RL1 streaming mode
      stream_mode_r <= rx_config[`RFB_CFG_STREAM];
      // RL5 DMA buffer size
      dma_buf_64k_r <= bus_control[`RFB_BUS_DMA_SIZE];
    end
  end

  // RL3 auto switch is applied through to_dma at frame end
endmodule // rfb_rx_frame_buffer

/* rfb_consts.svh */
// Offsets, field positions, reset values and timing counts of the receive frame buffer
`ifndef RFB_CONSTS_SVH
`define RFB_CONSTS_SVH

// Register page byte offsets
`define RFB_OFS_RX_CONFIG 12'h106
`define RFB_OFS_RX_EVENT 12'h108
`define RFB_OFS_RX_ACCEPT 12'h10A
`define RFB_OFS_BUF_CONFIG 12'h116
`define RFB_OFS_BUF_EVENT 12'h118
`define RFB_OFS_ISQ 12'h120
`define RFB_OFS_BUS_CONTROL 12'h12E
`define RFB_OFS_RX_STATUS 12'h400
`define RFB_OFS_RX_LENGTH 12'h402
`define RFB_OFS_RX_DATA 12'h404

// Register numbers reported in the low bits of an event word
`define RFB_REGNUM_RX_EVENT 16'h0004
`define RFB_REGNUM_BUF_EVENT 16'h000C

// rx_config fields
`define RFB_CFG_SKIP 6
`define RFB_CFG_STREAM 7
`define RFB_CFG_DMA_ALWAYS 9
`define RFB_CFG_AUTO_DMA 10
`define RFB_CFG_IRQ_MASK 16'h7100
// bus_control fields
`define RFB_BUS_BOUNDED_HOLD 11
`define RFB_BUS_DMA_SIZE 15
// buffer_config and buffer_event fields
`define RFB_BUF_MISS 10
`define RFB_BUF_128 11
`define RFB_BUF_DEST 15

// Reset values
`define RFB_RST_CFG 16'h0000

// Frame geometry
`define RFB_DEST_LAST 11'd5
`define RFB_EARLY_LAST 11'd127
`define RFB_MAX_LEN 11'd1518
`define RFB_RAM_FULL 12'hFFF
`define RFB_AUTO_LOW 12'h800
`define RFB_DQ_DEPTH 3'd4

// Bounded DMA bus hold
`define RFB_CLK_PERIOD_NS 8
`define RFB_DMA_HOLD_NS 28000
`define RFB_DMA_HOLD_CYC (`RFB_DMA_HOLD_NS / `RFB_CLK_PERIOD_NS)

`endif

/* rfb_pkg.sv */
// Types shared by the receive frame buffer
package rfb_pkg;

  // One received byte with its frame qualifiers
  typedef struct packed {
    logic last;
    logic da_ok;
    logic accept;
    logic [3:0] kind;
    logic [7:0] data;
  } rfb_word_t;

  // One held frame
  typedef struct packed {
    logic [11:0] start;
    logic [10:0] len;
    logic [15:0] status;
    logic dma;
    logic commit;
  } rfb_desc_t;

  typedef enum logic {RFB_RECV, RFB_DROP} rfb_wr_state_t;

endpackage

/* rfb_rx_frame_buffer_properties.sv */
// Port checker for the receive frame buffer, bound to its top module
`include "rfb_consts.svh"

////////////////////////////////////////////////////////////////////////////////
module rfb_rx_frame_buffer_properties (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic pp_rd,
  input wire logic pp_wr,
  input wire logic [11:0] pp_addr,
  input wire logic [15:0] pp_wdata,
  input wire logic io_rd,
  input wire logic [15:0] rdata_r,
  input wire logic rvalid_r,
  input wire logic irq_r,
  input wire logic dma_req_r,
  input wire logic stream_mode_r,
  input wire logic dma_buf_64k_r
);
  import rfb_pkg::*;
  localparam int HOLD = 3500;
  logic bound_r;
  int unsigned hold_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Tracks the bounded-hold bit as written
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bound_r <= 1'b0;
    end else if (ce && pp_wr && pp_addr == `RFB_OFS_BUS_CONTROL) begin
      bound_r <= pp_wdata[`RFB_BUS_BOUNDED_HOLD];
    end
  end

  // Length of the current unbroken request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= 0;
    end else if (!dma_req_r) begin
      hold_r <= 0;
    end else if (ce) begin
      hold_r <= hold_r + 1;
    end
  end

  rd_answer_a: assert property (ce && (pp_rd || io_rd) |=> rvalid_r)
    else $error("read got no answer");
  answer_cause_a: assert property ($rose(rvalid_r) |-> $past(pp_rd) || $past(io_rd))
    else $error("answer without a read");
  stream_bit_a: assert property (ce && pp_wr && pp_addr == `RFB_OFS_RX_CONFIG
    |-> ##2 stream_mode_r == $past(pp_wdata[`RFB_CFG_STREAM], 2))
    else $error("stream mode does not follow config");
  buf_size_a: assert property (ce && pp_wr && pp_addr == `RFB_OFS_BUS_CONTROL
    |-> ##2 dma_buf_64k_r == $past(pp_wdata[`RFB_BUS_DMA_SIZE], 2))
    else $error("buffer size does not follow bus control");
  unmapped_zero_a: assert property (ce && pp_rd && pp_addr == 12'h200 |=> rdata_r == 16'h0000)
    else $error("unmapped read not zero");
  skip_reads_zero_a: assert property (ce && pp_rd && pp_addr == `RFB_OFS_RX_CONFIG
    |=> !rdata_r[`RFB_CFG_SKIP])
    else $error("skip bit reads back set");
  rx_regnum_a: assert property (ce && pp_rd && pp_addr == `RFB_OFS_RX_EVENT
    |=> rdata_r[5:0] == 6'h04)
    else $error("receive event number wrong");
  buf_regnum_a: assert property (ce && pp_rd && pp_addr == `RFB_OFS_BUF_EVENT
    |=> rdata_r[5:0] == 6'h0C)
    else $error("buffer event number wrong");
  early_excl_a: assert property (ce && pp_rd && pp_addr == `RFB_OFS_BUF_EVENT
    |=> !(rdata_r[`RFB_BUF_DEST] && rdata_r[`RFB_BUF_128]))
    else $error("both early flags set");
  dma_hold_a: assert property (bound_r |-> hold_r <= HOLD)
    else $error("bounded DMA hold exceeded");

  cover property (rvalid_r && rdata_r[8]);
  cover property ($rose(dma_req_r));
  cover property ($rose(irq_r));
endmodule // rfb_rx_frame_buffer_properties

bind rfb_rx_frame_buffer rfb_rx_frame_buffer_properties chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .ce(ce), .pp_rd(pp_rd), .pp_wr(pp_wr), .pp_addr(pp_addr), .pp_wdata(pp_wdata),
  .io_rd(io_rd), .rdata_r(rdata_r), .rvalid_r(rvalid_r), .irq_r(irq_r),
  .dma_req_r(dma_req_r), .stream_mode_r(stream_mode_r), .dma_buf_64k_r(dma_buf_64k_r));

/* rfb_host_model.sv */
// Host model: page and I/O accesses, DMA word acceptance
module rfb_host_model (
  input wire logic ref_clk,
  output logic pp_rd,
  output logic pp_wr,
  output logic [11:0] pp_addr,
  output logic [15:0] pp_wdata,
  output logic io_rd,
  input wire logic [15:0] rdata_r,
  input wire logic rvalid_r,
  input wire logic dma_req_r,
  output logic dma_ack,
  input wire logic [15:0] dma_data_r
);
  timeunit 1ns;
  timeprecision 100ps;
  logic slow = 1'b0;
  logic took = 1'b0;
  logic [15:0] dq[$];

  initial begin
    {pp_rd, pp_wr, io_rd, dma_ack} = 4'h0;
    pp_addr = 12'h000;
    pp_wdata = 16'h0000;
  end

  task automatic acc(input logic w, input logic io, input logic [11:0] a,
                     input logic [15:0] wd, output logic [15:0] d);
    pp_rd = !w && !io;
    pp_wr = w;
    io_rd = io;
    pp_addr = a;
    pp_wdata = wd;
    @(posedge ref_clk);
    #1;
    {pp_rd, pp_wr, io_rd} = 3'h0;
    // Released lines must not look like a held request
    pp_addr = ~a;
    pp_wdata = ~wd;
    d = rvalid_r ? rdata_r : 16'hXXXX;
    @(posedge ref_clk);
    #1;
  endtask

  // DMA word acceptance, slow mode acks every other cycle
  always @(posedge ref_clk) begin
    if (took) begin
      dq.push_back(dma_data_r);
    end
    took = dma_req_r && dma_ack;
    #1;
    dma_ack = dma_req_r && (!slow || !dma_ack);
  end
endmodule // rfb_host_model

/* rfb_rx_frame_buffer_test.sv */
// Self-checking bench for the receive frame buffer
`include "rfb_consts.svh"

module rfb_rx_frame_buffer_test;
  timeunit 1ns;
  timeprecision 100ps;
  import rfb_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic rx_valid = 1'b0;
  rfb_word_t rx_word = '0;
  logic rx_ready, pp_rd, pp_wr, io_rd, rvalid_r, irq_r, dma_req_r, dma_ack, strm, b64;
  logic [11:0] pp_addr;
  logic [15:0] pp_wdata, rdata_r, dma_data_r;
  int n_mismatch = 0;
  int checks_done = 0;

  always #4 ref_clk = ~ref_clk;

  rfb_rx_frame_buffer DUT (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .rx_valid(rx_valid),
    .rx_word(rx_word), .rx_ready(rx_ready), .pp_rd(pp_rd), .pp_wr(pp_wr), .pp_addr(pp_addr),
    .pp_wdata(pp_wdata), .io_rd(io_rd), .rdata_r(rdata_r), .rvalid_r(rvalid_r),
    .irq_r(irq_r), .dma_req_r(dma_req_r), .dma_ack(dma_ack), .dma_data_r(dma_data_r),
    .stream_mode_r(strm), .dma_buf_64k_r(b64));
  rfb_host_model host (.ref_clk(ref_clk), .pp_rd(pp_rd), .pp_wr(pp_wr), .pp_addr(pp_addr),
    .pp_wdata(pp_wdata), .io_rd(io_rd), .rdata_r(rdata_r), .rvalid_r(rvalid_r),
    .dma_req_r(dma_req_r), .dma_ack(dma_ack), .dma_data_r(dma_data_r));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    host.acc(1'b0, 1'b0, a, 16'h0000, d);
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    logic [15:0] d;
    host.acc(1'b1, 1'b0, a, v, d);
  endtask

  // Bytes count up from b0; fin marks the last one as end of frame
  task automatic send(input int n, input logic da, input logic ac, input logic [3:0] kd,
                      input logic [7:0] b0, input logic fin);
    int k;
    for (int i = 0; i < n; i++) begin
      rx_valid = 1'b1;
      rx_word = '{last: fin && i == n - 1, da_ok: da, accept: ac, kind: kd, data: b0 + 8'(i)};
      k = 0;
      do begin
        @(posedge ref_clk);
        k++;
      end while (!rx_ready && k < 300);
      if (k >= 300) begin
        n_mismatch++;
        final_report();
      end
      #1;
    end
    rx_valid = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_cfg();
    logic [15:0] d;
    wr(`RFB_OFS_RX_CONFIG, 16'h0080);
    chk({15'h0000, strm}, 16'h0001);
    rd(`RFB_OFS_RX_CONFIG, d);
    chk(d, 16'h0080);
    wr(`RFB_OFS_RX_CONFIG, 16'h0040);
    rd(`RFB_OFS_RX_CONFIG, d);
    chk(d, 16'h0000);
    wr(`RFB_OFS_BUS_CONTROL, 16'h8000);
    chk({15'h0000, b64}, 16'h0001);
    wr(`RFB_OFS_BUS_CONTROL, 16'h0000);
    chk({15'h0000, b64}, 16'h0000);
    rd(12'h200, d);
    chk(d, 16'h0000);
    $display("test cfg done");
  endtask

  task automatic t_frame();
    logic [15:0] d;
    wr(`RFB_OFS_RX_CONFIG, 16'h0100);
    send(6, 1'b1, 1'b1, 4'h1, 8'h10, 1'b0);
    chk({15'h0000, irq_r}, 16'h0000);
    send(1, 1'b1, 1'b1, 4'h1, 8'h16, 1'b1);
    chk({15'h0000, irq_r}, 16'h0001);
    rd(`RFB_OFS_RX_EVENT, d);
    chk(d, 16'h0104);
    rd(`RFB_OFS_RX_EVENT, d);
    chk(d, 16'h0004);
    rd(`RFB_OFS_RX_LENGTH, d);
    chk(d, 16'h0007);
    for (int i = 0; i < 3; i++) begin
      rd(`RFB_OFS_RX_DATA, d);
      chk(d, {8'h11 + 8'(2 * i), 8'h10 + 8'(2 * i)});
    end
    rd(`RFB_OFS_RX_DATA, d);
    chk({8'h00, d[7:0]}, 16'h0016);
    rd(`RFB_OFS_RX_DATA, d);
    chk(d, 16'h0000);
    $display("test frame done");
  endtask

  task automatic t_kinds();
    logic [15:0] d;
    logic [15:0] ev[4] = '{16'h0104, 16'h1004, 16'h2004, 16'h4004};
    for (int k = 0; k < 4; k++) begin
      send(4, 1'b1, 1'b1, 4'(1 << k), 8'h20 + 8'(16 * k), 1'b1);
      rd(`RFB_OFS_RX_EVENT, d);
      chk(d, ev[k]);
    end
    for (int k = 0; k < 4; k++) begin
      rd(`RFB_OFS_RX_DATA, d);
      chk(d, {8'h21 + 8'(16 * k), 8'h20 + 8'(16 * k)});
      wr(`RFB_OFS_RX_CONFIG, 16'h0040);
    end
    rd(`RFB_OFS_RX_DATA, d);
    chk(d, 16'h0000);
    send(8, 1'b0, 1'b1, 4'h1, 8'h70, 1'b1);
    rd(`RFB_OFS_RX_EVENT, d);
    chk(d, 16'h0004);
    rd(`RFB_OFS_RX_DATA, d);
    chk(d, 16'h0000);
    send(8, 1'b1, 1'b0, 4'h1, 8'h78, 1'b1);
    rd(`RFB_OFS_RX_DATA, d);
    chk(d, 16'h0000);
    $display("test kinds done");
  endtask

  task automatic t_early();
    logic [15:0] d;
    wr(`RFB_OFS_BUF_CONFIG, 16'h8800);
    rd(`RFB_OFS_BUF_EVENT, d);
    chk({15'h0000, irq_r}, 16'h0000);
    send(6, 1'b1, 1'b1, 4'h1, 8'h00, 1'b0);
    chk({15'h0000, irq_r}, 16'h0001);
    send(122, 1'b1, 1'b1, 4'h1, 8'h06, 1'b0);
    rd(`RFB_OFS_BUF_EVENT, d);
    chk(d, 16'h080C);
    rd(`RFB_OFS_BUF_EVENT, d);
    chk(d, 16'h000C);
    send(2, 1'b1, 1'b1, 4'h1, 8'h80, 1'b1);
    rd(`RFB_OFS_RX_LENGTH, d);
    chk(d, 16'h0082);
    rd(`RFB_OFS_RX_DATA, d);
    chk(d, 16'h0100);
    wr(`RFB_OFS_RX_CONFIG, 16'h0040);
    wr(`RFB_OFS_BUF_CONFIG, 16'h0000);
    $display("test early done");
  endtask

  task automatic t_io();
    logic [15:0] d;
    logic [15:0] ex[4] = '{16'h0005, 16'h4140, 16'h4342, 16'h0044};
    send(5, 1'b1, 1'b1, 4'h1, 8'h40, 1'b1);
    rd(`RFB_OFS_RX_EVENT, d);
    chk(d & 16'h0100, 16'h0100);
    host.acc(1'b0, 1'b1, 12'h000, 16'h0000, d);
    chk(d & 16'h0100, 16'h0100);
    for (int i = 0; i < 4; i++) begin
      host.acc(1'b0, 1'b1, 12'h000, 16'h0000, d);
      chk(i == 3 ? {8'h00, d[7:0]} : d, ex[i]);
    end
    rd(`RFB_OFS_RX_DATA, d);
    chk(d, 16'h0000);
    $display("test io done");
  endtask

  task automatic t_dma();
    logic [15:0] d;
    int k;
    host.slow = 1'b1;
    wr(`RFB_OFS_BUS_CONTROL, 16'h0800);
    wr(`RFB_OFS_RX_CONFIG, 16'h0200);
    send(4, 1'b1, 1'b1, 4'h1, 8'h60, 1'b1);
    k = 0;
    while (host.dq.size() < 2 && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    #1;
    if (k >= 200) begin
      n_mismatch++;
      final_report();
    end
    chk(host.dq[0], 16'h6160);
    chk(host.dq[1], 16'h6362);
    rd(`RFB_OFS_RX_DATA, d);
    chk(d, 16'h0000);
    wr(`RFB_OFS_RX_CONFIG, 16'h0000);
    $display("test dma done");
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    @(posedge ref_clk);
    #1;
    t_cfg();
    t_frame();
    t_kinds();
    t_early();
    t_io();
    t_dma();
    final_report();
  end
endmodule // rfb_rx_frame_buffer_test
